//--- logic/iosr_pkg.sv
/*
 Constants for the terminal signal-assignment router: assignment codes,
 terminal counts and field widths.
 Assumes an 8-bit assignment code per terminal, written by the host.
*/
package iosr_pkg;
   localparam int CODE_W = 8;
   localparam int NUM_FUNC = 128;
   localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;
   localparam logic [CODE_W-1:0] CODE_TOOL_UNLOCK = 8'h10;
   localparam logic [CODE_W-1:0] CODE_GEN_FIRST = 8'h50;
   localparam logic [CODE_W-1:0] CODE_GEN_LAST = 8'h5f;
   localparam logic [CODE_W-1:0] CODE_EXCITE = 8'h60;
   localparam logic [CODE_W-1:0] CODE_PROBE_ONE = 8'h68;
   localparam logic [CODE_W-1:0] CODE_PROBE_TWO = 8'h69;
   localparam logic [CODE_W-1:0] CODE_ECHO_LAST = 8'h7f;
   localparam logic [CODE_W-1:0] CODE_CONST_OFF = 8'h80;
   localparam logic [CODE_W-1:0] CODE_FAULT_HIGH = 8'h81;
   localparam logic [CODE_W-1:0] CODE_FAULT_LOW = 8'h82;
   localparam logic [CODE_W-1:0] CODE_SYS_PREP = 8'h83;
   localparam logic [CODE_W-1:0] CODE_READY = 8'h84;
   localparam logic [CODE_W-1:0] CODE_PULSE_EN = 8'h85;
   localparam logic [CODE_W-1:0] CODE_MOVING = 8'h86;
   localparam int NUM_GEN = 16;
   localparam int NUM_DIRECT = 6;
   localparam int NUM_REMOTE = 16;
   localparam int NUM_OUT = 16;
endpackage : iosr_pkg

//--- logic/iosr_router.sv
/*
 Signal-assignment router: routes direct and remote input terminals to
 internal functions by code, and selects each output terminal's source.
 Assumes terminal levels and codes are synchronous to clk; status inputs
 come from the driver core. Results are registered, one cycle latency; outputs echoing input functions take two.
*/
`timescale 1ns/1ns
module iosr_router
   import iosr_pkg::*;
#(
   parameter int N_DIR = NUM_DIRECT,
   parameter int N_REM = NUM_REMOTE,
   parameter int N_OUT = NUM_OUT
) (
   input wire logic clk, // 100 MHz clock
   input wire logic rst_b, // Async reset, active low
   input wire logic [N_DIR-1:0] directIn, // Direct input terminal levels
   input wire logic [N_REM-1:0] remoteIn, // Remote input terminal levels
   input wire logic [N_DIR*CODE_W-1:0] directCode, // Direct input codes
   input wire logic [N_REM*CODE_W-1:0] remoteCode, // Remote input codes
   input wire logic [N_OUT*CODE_W-1:0] outCode, // Output terminal codes
   input wire logic alarmPresent, // Driver alarm active
   input wire logic sysPrepared, // System preparation done
   input wire logic driverReady, // Driver ready to operate
   input wire logic pulseEnabled, // Pulse input enabled
   input wire logic motorMoving, // Motor operating
   output logic [NUM_FUNC-1:0] funcState, // Input function states
   output logic [NUM_GEN-1:0] generalBits, // General-purpose bits
   output logic excitationRequest, // Motor excitation request
   output logic probeOneLatchIn, // Probe one latch trigger
   output logic probeTwoLatchIn, // Probe two latch trigger
   output logic toolUnlockInput, // Tool-unlock function
   output logic [N_OUT-1:0] outTerm // Output terminal levels
);

   localparam int GEN_LO = int'(CODE_GEN_FIRST);
   localparam int TOOL_IX = int'(CODE_TOOL_UNLOCK);

   logic [NUM_FUNC-1:0] next_funcState;
   logic [NUM_GEN-1:0] next_generalBits;
   logic next_excitationRequest;
   logic next_probeOneLatchIn;
   logic next_probeTwoLatchIn;
   logic next_toolUnlockInput;
   logic [N_OUT-1:0] next_outTerm;

   // Input routing: OR of all terminals carrying each code; tool unlock ANDs direct and remote when both carry it, is 1 when none does
   always_comb begin
      logic [NUM_FUNC-1:0] dirHit;
      logic [NUM_FUNC-1:0] remHit;
      logic dirTool;
      logic remTool;
      logic [CODE_W-1:0] c;
      dirHit = '0;
      remHit = '0;
      dirTool = 1'b0;
      remTool = 1'b0;
      c = CODE_NONE;
      for (int i = 0; i < N_DIR; i++) begin
         c = directCode[i*CODE_W +: CODE_W];
         if (c != CODE_NONE && c <= CODE_ECHO_LAST) begin
            dirHit[c[6:0]] = dirHit[c[6:0]] | directIn[i];
         end
         if (c == CODE_TOOL_UNLOCK) begin
            dirTool = 1'b1;
         end
      end
      for (int j = 0; j < N_REM; j++) begin
         c = remoteCode[j*CODE_W +: CODE_W];
         if (c != CODE_NONE && c <= CODE_ECHO_LAST) begin
            remHit[c[6:0]] = remHit[c[6:0]] | remoteIn[j];
         end
         if (c == CODE_TOOL_UNLOCK) begin
            remTool = 1'b1;
         end
      end
      next_funcState = dirHit | remHit;
      if (!dirTool && !remTool) begin
         next_funcState[TOOL_IX] = 1'b1;
      end else if (dirTool && remTool) begin
         next_funcState[TOOL_IX] = dirHit[TOOL_IX] & remHit[TOOL_IX];
      end
      next_generalBits = next_funcState[GEN_LO +: NUM_GEN];
      next_excitationRequest = next_funcState[CODE_EXCITE[6:0]];
      next_probeOneLatchIn = next_funcState[CODE_PROBE_ONE[6:0]];
      next_probeTwoLatchIn = next_funcState[CODE_PROBE_TWO[6:0]];
      next_toolUnlockInput = next_funcState[TOOL_IX];
   end

   // Output selection per terminal, echoing registered function state
   always_comb begin
      logic [CODE_W-1:0] oc;
      oc = CODE_NONE;
      next_outTerm = '0;
      for (int k = 0; k < N_OUT; k++) begin
         oc = outCode[k*CODE_W +: CODE_W];
         case (oc)
            CODE_NONE: next_outTerm[k] = 1'b0;
            CODE_CONST_OFF: next_outTerm[k] = 1'b0;
            CODE_FAULT_HIGH: next_outTerm[k] = alarmPresent;
            CODE_FAULT_LOW: next_outTerm[k] = ~alarmPresent;
            CODE_SYS_PREP: next_outTerm[k] = sysPrepared;
            CODE_READY: next_outTerm[k] = driverReady;
            CODE_PULSE_EN: next_outTerm[k] = pulseEnabled;
            CODE_MOVING: next_outTerm[k] = motorMoving;
            default: begin
               if (oc <= CODE_ECHO_LAST) begin
                  next_outTerm[k] = funcState[oc[6:0]];
               end else begin
                  next_outTerm[k] = 1'b0;
               end
            end
         endcase
      end
   end

   // Register all results
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         funcState <= '0;
         generalBits <= '0;
         excitationRequest <= 1'b0;
         probeOneLatchIn <= 1'b0;
         probeTwoLatchIn <= 1'b0;
         toolUnlockInput <= 1'b0;
         outTerm <= '0;
      end else begin
         funcState <= next_funcState;
         generalBits <= next_generalBits;
         excitationRequest <= next_excitationRequest;
         probeOneLatchIn <= next_probeOneLatchIn;
         probeTwoLatchIn <= next_probeTwoLatchIn;
         toolUnlockInput <= next_toolUnlockInput;
         outTerm <= next_outTerm;
      end
   end

   // Check helper: tool-unlock code seen on any terminal
   logic toolSeen;
   always_comb begin
      toolSeen = 1'b0;
      for (int t = 0; t < N_DIR; t++) begin
         if (directCode[t*CODE_W +: CODE_W] == CODE_TOOL_UNLOCK) begin
            toolSeen = 1'b1;
         end
      end
      for (int u = 0; u < N_REM; u++) begin
         if (remoteCode[u*CODE_W +: CODE_W] == CODE_TOOL_UNLOCK) begin
            toolSeen = 1'b1;
         end
      end
   end

   // Checks, written from terminal inputs rather than internal state, except p_zero on funcState
   property p_excite;
      @(posedge clk) disable iff (!rst_b)
      directCode[CODE_W-1:0] == CODE_EXCITE && directIn[0]
         |=> excitationRequest;
   endproperty
   a_excite: assert property (p_excite) else $error("excite mismatch");
   property p_gen;
      @(posedge clk) disable iff (!rst_b)
      remoteCode[CODE_W-1:0] == CODE_GEN_FIRST && remoteIn[0]
         |=> generalBits[0];
   endproperty
   a_gen: assert property (p_gen) else $error("general bits mismatch");
   property p_probe;
      @(posedge clk) disable iff (!rst_b)
      (directCode[CODE_W-1:0] == CODE_PROBE_ONE && directIn[0]
         |=> probeOneLatchIn)
      and (remoteCode[CODE_W-1:0] == CODE_PROBE_TWO && remoteIn[0]
         |=> probeTwoLatchIn);
   endproperty
   a_probe: assert property (p_probe) else $error("probe mismatch");
   property p_tool;
      @(posedge clk) disable iff (!rst_b)
      !toolSeen |=> toolUnlockInput;
   endproperty
   a_tool: assert property (p_tool) else $error("tool unlock mismatch");
   property p_zero;
      @(posedge clk) disable iff (!rst_b)
      funcState[0] == 1'b0;
   endproperty
   a_zero: assert property (p_zero) else $error("code zero active");
   property p_off;
      @(posedge clk) disable iff (!rst_b)
      outCode[CODE_W-1:0] == CODE_CONST_OFF |=> !outTerm[0];
   endproperty
   a_off: assert property (p_off) else $error("const off high");
   property p_fhi;
      @(posedge clk) disable iff (!rst_b)
      outCode[CODE_W-1:0] == CODE_FAULT_HIGH
         |=> outTerm[0] == $past(alarmPresent);
   endproperty
   a_fhi: assert property (p_fhi) else $error("fault high wrong");
   property p_flo;
      @(posedge clk) disable iff (!rst_b)
      outCode[CODE_W-1:0] == CODE_FAULT_LOW |=> outTerm[0] != $past(alarmPresent);
   endproperty
   a_flo: assert property (p_flo) else $error("fault low wrong");
   property p_move;
      @(posedge clk) disable iff (!rst_b)
      outCode[CODE_W-1:0] == CODE_MOVING |=> outTerm[0] == $past(motorMoving);
   endproperty
   a_move: assert property (p_move) else $error("moving wrong");
   property p_none;
      @(posedge clk) disable iff (!rst_b)
      outCode[CODE_W-1:0] == CODE_NONE |=> !outTerm[0];
   endproperty
   a_none: assert property (p_none) else $error("unused output high");
   c_excite: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(excitationRequest));
   c_probe: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(probeOneLatchIn));
   c_toolLow: cover property (@(posedge clk) disable iff (!rst_b)
      !toolUnlockInput);

endmodule // iosr_router

//--- verification/iosr_term_model.sv
/* Terminal and host model: drives terminal levels and codes.
 Assumes the bench hands it the wanted levels and codes each cycle. */
`timescale 1ns/1ns
module iosr_term_model
   import iosr_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic [21:0] lvl, // Wanted levels, remote over direct
   input wire logic [22*CODE_W-1:0] codes, // Wanted codes, same order
   output logic [NUM_DIRECT-1:0] directIn, // Direct levels
   output logic [NUM_REMOTE-1:0] remoteIn, // Remote levels
   output logic [NUM_DIRECT*CODE_W-1:0] directCode, // Direct codes
   output logic [NUM_REMOTE*CODE_W-1:0] remoteCode // Remote codes
);
   always_ff @(posedge clk) begin
      {remoteIn, directIn} <= lvl;
      {remoteCode, directCode} <= codes;
   end
endmodule // iosr_term_model

//--- verification/tb_iosr_router.sv
/* Self-checking bench: random codes and levels against a model.
 Assumes a 100 MHz clock and one cycle of router latency, two for outputs echoing input functions. */
`timescale 1ns/1ns
module tb_iosr_router
   import iosr_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [21:0] lvl = '0;
   logic [22*CODE_W-1:0] codes = '0;
   logic [22*CODE_W-1:0] nc;
   logic [NUM_OUT*CODE_W-1:0] outCode = '0;
   logic [NUM_OUT*CODE_W-1:0] no;
   logic [4:0] stat = '0;
   logic [15:0] rnd = 16'h0019;
   logic [NUM_DIRECT-1:0] directIn;
   logic [NUM_REMOTE-1:0] remoteIn;
   logic [NUM_DIRECT*CODE_W-1:0] directCode;
   logic [NUM_REMOTE*CODE_W-1:0] remoteCode;
   logic [NUM_FUNC-1:0] funcState;
   logic [NUM_FUNC-1:0] expF = '0;
   logic [NUM_GEN-1:0] generalBits;
   logic excitationRequest, probeOneLatchIn, probeTwoLatchIn;
   logic toolUnlockInput;
   logic [NUM_OUT-1:0] outTerm;
   logic [NUM_OUT-1:0] expO = '0;
   int nErrors = 0;
   int testsRun = 0;
   int cyc = 0;
   logic [CODE_W-1:0] inTab [16] = '{8'h00, 8'h10, 8'h50, 8'h5f, 8'h60,
      8'h68, 8'h69, 8'h07, 8'h00, 8'h10, 8'h51, 8'h57, 8'h60, 8'h68,
      8'h69, 8'h9a};
   logic [CODE_W-1:0] outTab [16] = '{8'h00, 8'h10, 8'h60, 8'h68, 8'h50,
      8'h5f, 8'h07, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'hc8,
      8'h7f};

   iosr_term_model term_u (.clk(clk), .lvl(lvl), .codes(codes),
      .directIn(directIn), .remoteIn(remoteIn), .directCode(directCode),
      .remoteCode(remoteCode));
   iosr_router dut_u (.clk(clk), .rst_b(rst_b), .directIn(directIn),
      .remoteIn(remoteIn), .directCode(directCode), .remoteCode(remoteCode),
      .outCode(outCode), .alarmPresent(stat[0]), .sysPrepared(stat[1]),
      .driverReady(stat[2]), .pulseEnabled(stat[3]), .motorMoving(stat[4]),
      .funcState(funcState), .generalBits(generalBits),
      .excitationRequest(excitationRequest), .probeOneLatchIn(probeOneLatchIn),
      .probeTwoLatchIn(probeTwoLatchIn), .toolUnlockInput(toolUnlockInput),
      .outTerm(outTerm));

   // Clock
   always #5 clk = ~clk;

   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Input function model
   function automatic logic [NUM_FUNC-1:0] inModel(input logic [21:0] l,
      input logic [22*CODE_W-1:0] c);
      logic [NUM_FUNC-1:0] f;
      logic [CODE_W-1:0] k;
      logic da, ra, dv, rv;
      f = '0;
      {da, ra, dv, rv} = 4'h0;
      for (int i = 0; i < 22; i++) begin
         k = c[i*CODE_W +: CODE_W];
         if (k != 8'h00 && k < 8'h80) f[k[6:0]] = f[k[6:0]] | l[i];
         if (k == CODE_TOOL_UNLOCK && i < NUM_DIRECT)
            {da, dv} = {1'b1, dv | l[i]};
         if (k == CODE_TOOL_UNLOCK && i >= NUM_DIRECT)
            {ra, rv} = {1'b1, rv | l[i]};
      end
      f[16] = (da && ra) ? (dv && rv) : (da ? dv : (ra ? rv : 1'b1));
      return f;
   endfunction

   // Output terminal model
   function automatic logic outModel(input logic [CODE_W-1:0] k,
      input logic [4:0] s, input logic [NUM_FUNC-1:0] f);
      if (k == CODE_NONE || k == CODE_CONST_OFF) return 1'b0;
      if (k < CODE_CONST_OFF) return f[k[6:0]];
      case (k)
         CODE_FAULT_HIGH: return s[0];
         CODE_FAULT_LOW: return !s[0];
         CODE_SYS_PREP: return s[1];
         CODE_READY: return s[2];
         CODE_PULSE_EN: return s[3];
         CODE_MOVING: return s[4];
         default: return 1'b0;
      endcase
   endfunction

   task automatic chkFunc(input logic [NUM_FUNC-1:0] got, exp);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] %0t functions %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chkOut(input logic [NUM_OUT-1:0] got, exp);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] %0t outputs %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (nErrors == 0 && testsRun > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Model registers, one cycle behind the inputs
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         expF <= '0;
         expO <= '0;
      end else begin
         for (int k = 0; k < NUM_OUT; k++)
            expO[k] <= outModel(outCode[k*CODE_W +: CODE_W], stat, expF);
         expF <= inModel({remoteIn, directIn}, {remoteCode, directCode});
      end
   end

   // Compare at settled points
   always @(negedge clk) begin
      chkFunc(funcState, expF);
      chkFunc({112'h0, generalBits}, {112'h0, expF[95:80]});
      chkFunc({127'h0, excitationRequest}, {127'h0, expF[96]});
      chkFunc({126'h0, probeTwoLatchIn, probeOneLatchIn},
         {126'h0, expF[105:104]});
      chkFunc({127'h0, toolUnlockInput}, {127'h0, expF[16]});
      chkOut(outTerm, expO);
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         nErrors++;
         tally_and_finish();
      end
   end

   // Stimulus: phases without tool unlock, direct only, then free
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      for (int n = 0; n < 3000; n++) begin
         @(posedge clk);
         for (int i = 0; i < 22; i++) begin
            rnd = lfsrNext(rnd);
            nc[i*CODE_W +: CODE_W] = inTab[rnd[3:0]];
            if (rnd[2:0] == 3'h1 &&
               (n < 1000 || (n < 2000 && i >= NUM_DIRECT)))
               nc[i*CODE_W +: CODE_W] = CODE_NONE;
         end
         for (int k = 0; k < NUM_OUT; k++) begin
            rnd = lfsrNext(rnd);
            no[k*CODE_W +: CODE_W] = outTab[rnd[3:0]];
         end
         codes <= nc;
         outCode <= no;
         lvl <= {rnd[5:0], lfsrNext(rnd)};
         stat <= rnd[10:6];
         rst_b <= (n % 1500) != 700;
      end
      repeat (3) @(posedge clk);
      tally_and_finish();
   end
endmodule // tb_iosr_router
